//--- inc/eim1_defs.vh
// Constants for the extended interrupt mask one register
`ifndef EIM1_DEFS_VH
`define EIM1_DEFS_VH
`define EIM1_RESET 8'h00
`define EIM1_USED_MASK 8'hFD
`define EIM1_BIT_TIMER3 7
`define EIM1_BIT_CMP1 6
`define EIM1_BIT_CMP0 5
`define EIM1_BIT_COUNTER 4
`define EIM1_BIT_CONV 3
`define EIM1_BIT_WINDOW 2
`define EIM1_BIT_UNUSED 1
`define EIM1_BIT_TWO_WIRE 0
`define EIM1_NUM_SRC 8
`endif

//--- test/eim1_monitor.sv
// Mask gating checker
`timescale 1ns/10ps
`include "eim1_defs.vh"
module eim1_monitor #(
  parameter COUNTER_SRCS = 6
) (
  input wire sys_clk,
  input wire arst_n,
  input wire global_irq_enable,
  input wire timer3_low_overflow_flag,
  input wire timer3_high_overflow_flag,
  input wire comparator1_rise_flag,
  input wire comparator1_fall_flag,
  input wire [COUNTER_SRCS-1:0] counter_array_flags,
  input wire conversion_done_flag,
  input wire [7:0] reg_rdata,
  input wire timer3_irq,
  input wire comparator1_irq,
  input wire counter_array_irq,
  input wire conversion_done_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_t3_armed;
    (timer3_low_overflow_flag | timer3_high_overflow_flag) & reg_rdata[`EIM1_BIT_TIMER3] & global_irq_enable;
  endsequence
  sequence s_c1_armed;
    (comparator1_rise_flag | comparator1_fall_flag) & reg_rdata[`EIM1_BIT_CMP1] & global_irq_enable;
  endsequence
  sequence s_ca_armed;
    (|counter_array_flags) & reg_rdata[`EIM1_BIT_COUNTER] & global_irq_enable;
  endsequence
  sequence s_conv_armed;
    conversion_done_flag & reg_rdata[`EIM1_BIT_CONV] & global_irq_enable;
  endsequence
  AST_ON: assert property (s_t3_armed |=> timer3_irq) else $error("timer3 request not forwarded");
  AST_MASK: assert property (!reg_rdata[`EIM1_BIT_TIMER3] |=> !timer3_irq) else $error("timer3 request leaked");
  AST_C1_ON: assert property (s_c1_armed |=> comparator1_irq) else $error("comparator1 request not forwarded");
  AST_C1_MASK: assert property (!reg_rdata[`EIM1_BIT_CMP1] |=> !comparator1_irq) else $error("comparator1 leaked");
  AST_CA_ON: assert property (s_ca_armed |=> counter_array_irq) else $error("counter request not forwarded");
  AST_CA_MASK: assert property (!reg_rdata[`EIM1_BIT_COUNTER] |=> !counter_array_irq) else $error("counter leaked");
  AST_CONV_ON: assert property (s_conv_armed |=> conversion_done_irq) else $error("conversion not forwarded");
  AST_CONV_MASK: assert property (!reg_rdata[`EIM1_BIT_CONV] |=> !conversion_done_irq) else $error("conv leaked");
  AST_OFF: assert property (!global_irq_enable |=> !(timer3_irq | comparator1_irq | counter_array_irq |
    conversion_done_irq)) else $error("request passed with global enable clear");
  AST_RST: assert property ($rose(arst_n) |-> reg_rdata == `EIM1_RESET) else $error("mask not cleared by reset");
  AST_B1: assert property (!reg_rdata[`EIM1_BIT_UNUSED]) else $error("unused bit reads one");
  AST_RISE: assert property ($rose(timer3_irq) |-> $past(reg_rdata[`EIM1_BIT_TIMER3] & global_irq_enable))
    else $error("timer3 request rose without enables");
endmodule
bind eim1_top eim1_monitor #(.COUNTER_SRCS(COUNTER_SRCS)) mon (.sys_clk, .arst_n, .global_irq_enable,
  .timer3_low_overflow_flag, .timer3_high_overflow_flag, .comparator1_rise_flag, .comparator1_fall_flag,
  .counter_array_flags, .conversion_done_flag, .reg_rdata, .timer3_irq, .comparator1_irq, .counter_array_irq,
  .conversion_done_irq);

//--- test/eim1_partner.sv
// Peripheral request flag model
`timescale 1ns/10ps
module eim1_partner (
  input wire sys_clk,
  input wire [14:0] want,
  output reg [14:0] flags
);
  // Flags lag one edge, as a real peripheral does
  always @(posedge sys_clk) flags <= #1 want;
endmodule

//--- test/eim1_top_tb.sv
// Mask gating testbench
`timescale 1ns/10ps
module eim1_top_tb;
  reg sys_clk = 0, arst_n = 0, reg_wr = 0, global_irq_enable = 0;
  reg [7:0] reg_wdata = 8'h00;
  reg [14:0] w = 15'h0000;
  wire [14:0] f;
  wire [7:0] reg_rdata;
  wire [6:0] q;
  integer n_mismatch = 0, compares = 0;
  eim1_partner fm (.sys_clk, .want(w), .flags(f));
  eim1_top uut (.sys_clk, .arst_n, .reg_wr, .reg_wdata, .reg_rdata, .global_irq_enable,
    .timer3_low_overflow_flag(f[0]), .timer3_high_overflow_flag(f[1]), .comparator1_rise_flag(f[2]),
    .comparator1_fall_flag(f[3]), .comparator0_rise_flag(f[4]), .comparator0_fall_flag(f[5]),
    .counter_array_flags(f[11:6]), .conversion_done_flag(f[12]), .window_compare_flag(f[13]),
    .two_wire_port_flag(f[14]), .timer3_irq(q[6]), .comparator1_irq(q[5]), .comparator0_irq(q[4]),
    .counter_array_irq(q[3]), .conversion_done_irq(q[2]), .window_compare_irq(q[1]), .two_wire_port_irq(q[0]));
  initial forever #2 sys_clk = ~sys_clk;
  task run(input rs, input [7:0] m, input g, input [14:0] v, x);
    @(posedge sys_clk) #1 {arst_n, reg_wr, reg_wdata, global_irq_enable, w} = {!rs, 1'b1, m, g, v};
    @(posedge sys_clk) #1 {arst_n, reg_wr} = 2'b10;
    repeat (2) @(posedge sys_clk);
    #1 compares = compares + 1;
    if ({q, reg_rdata} !== x) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value irq_mask exp %h got %h", x, {q, reg_rdata});
    end
  endtask
  task sc_gate;
    run(0, 8'hFD, 1, 15'h0000, 15'h00FD);
    run(0, 8'h80, 1, 15'h0001, 15'h4080);
    run(0, 8'h80, 1, 15'h0002, 15'h4080);
    run(0, 8'h40, 1, 15'h0008, 15'h2040);
    run(0, 8'h40, 1, 15'h0004, 15'h2040);
    run(0, 8'h10, 1, 15'h0040, 15'h0810);
    run(0, 8'h10, 1, 15'h0080, 15'h0810);
    run(0, 8'h10, 1, 15'h0100, 15'h0810);
    run(0, 8'h10, 1, 15'h0200, 15'h0810);
    run(0, 8'h10, 1, 15'h0400, 15'h0810);
    run(0, 8'h10, 1, 15'h0800, 15'h0810);
    run(0, 8'h08, 1, 15'h1000, 15'h0408);
    run(0, 8'h25, 1, 15'h7FFF, 15'h1325);
  endtask
  task sc_global_reset;
    run(0, 8'hFF, 0, 15'h7FFF, 15'h00FD);
    run(1, 8'hFF, 1, 15'h7FFF, 15'h0000);
  endtask
  task tally_and_finish;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 arst_n = 1;
    sc_gate;
    sc_global_reset;
    tally_and_finish;
  end
  initial begin
    #2000 n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
endmodule

//--- verilog/eim1_gate.v
// Per-source request gate with global enable
`timescale 1ns/10ps
module eim1_gate #(
  parameter WIDTH = 8
) (
  input wire [WIDTH-1:0] raw_req,
  input wire [WIDTH-1:0] mask,
  input wire global_enable,
  output wire [WIDTH-1:0] gated_req
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_src
      assign gated_req[i] = raw_req[i] & mask[i] & global_enable;
    end
  endgenerate
endmodule

//--- verilog/eim1_top.v
// Extended interrupt mask one register and request gating
// Operation
// - Bit 7 set forwards timer 3 low or high overflow; clear blocks both.
// - Bit 6 set forwards comparator 1 rise or fall flag; clear blocks both.
// - Bit 4 set passes all counter array requests; clear blocks them all.
// - Bit 3 set passes conversion-done flag as request; clear suppresses it.
// - Mask bits only matter while global enable is set; else all blocked.
`timescale 1ns/10ps
`include "eim1_defs.vh"
module eim1_top #(
  parameter COUNTER_SRCS = 6
) (
  input wire sys_clk,
  input wire arst_n,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output wire [7:0] reg_rdata,
  input wire global_irq_enable,
  input wire timer3_low_overflow_flag,
  input wire timer3_high_overflow_flag,
  input wire comparator1_rise_flag,
  input wire comparator1_fall_flag,
  input wire comparator0_rise_flag,
  input wire comparator0_fall_flag,
  input wire [COUNTER_SRCS-1:0] counter_array_flags,
  input wire conversion_done_flag,
  input wire window_compare_flag,
  input wire two_wire_port_flag,
  output reg timer3_irq,
  output reg comparator1_irq,
  output reg comparator0_irq,
  output reg counter_array_irq,
  output reg conversion_done_irq,
  output reg window_compare_irq,
  output reg two_wire_port_irq
);
  localparam [7:0] RESET_VALUE = `EIM1_RESET;
  reg timer3_irq_mask;
  reg comparator1_irq_mask;
  reg comparator0_irq_mask;
  reg counter_array_irq_mask;
  reg conversion_done_irq_mask;
  reg window_compare_irq_mask;
  reg two_wire_port_irq_mask;
  reg next_timer3_irq_mask;
  reg next_comparator1_irq_mask;
  reg next_comparator0_irq_mask;
  reg next_counter_array_irq_mask;
  reg next_conversion_done_irq_mask;
  reg next_window_compare_irq_mask;
  reg next_two_wire_port_irq_mask;
  reg next_timer3_irq;
  reg next_comparator1_irq;
  reg next_comparator0_irq;
  reg next_counter_array_irq;
  reg next_conversion_done_irq;
  reg next_window_compare_irq;
  reg next_two_wire_port_irq;
  wire [7:0] mask_vec;
  wire [7:0] raw_req;
  wire [7:0] gated_req;

  // Write decode; bit 1 has no flop, so a write to it is lost
  always @* begin
    next_timer3_irq_mask = timer3_irq_mask;
    next_comparator1_irq_mask = comparator1_irq_mask;
    next_comparator0_irq_mask = comparator0_irq_mask;
    next_counter_array_irq_mask = counter_array_irq_mask;
    next_conversion_done_irq_mask = conversion_done_irq_mask;
    next_window_compare_irq_mask = window_compare_irq_mask;
    next_two_wire_port_irq_mask = two_wire_port_irq_mask;
    if (reg_wr) begin
      next_timer3_irq_mask = reg_wdata[`EIM1_BIT_TIMER3];
      next_comparator1_irq_mask = reg_wdata[`EIM1_BIT_CMP1];
      next_comparator0_irq_mask = reg_wdata[`EIM1_BIT_CMP0];
      next_counter_array_irq_mask = reg_wdata[`EIM1_BIT_COUNTER];
      next_conversion_done_irq_mask = reg_wdata[`EIM1_BIT_CONV];
      next_window_compare_irq_mask = reg_wdata[`EIM1_BIT_WINDOW];
      next_two_wire_port_irq_mask = reg_wdata[`EIM1_BIT_TWO_WIRE];
    end
  end

  // One flop per field, so each source stays blocked until software opens it
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer3_irq_mask <= RESET_VALUE[`EIM1_BIT_TIMER3];
    end else begin
      timer3_irq_mask <= next_timer3_irq_mask;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      comparator1_irq_mask <= RESET_VALUE[`EIM1_BIT_CMP1];
    end else begin
      comparator1_irq_mask <= next_comparator1_irq_mask;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      comparator0_irq_mask <= RESET_VALUE[`EIM1_BIT_CMP0];
    end else begin
      comparator0_irq_mask <= next_comparator0_irq_mask;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      counter_array_irq_mask <= RESET_VALUE[`EIM1_BIT_COUNTER];
    end else begin
      counter_array_irq_mask <= next_counter_array_irq_mask;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conversion_done_irq_mask <= RESET_VALUE[`EIM1_BIT_CONV];
    end else begin
      conversion_done_irq_mask <= next_conversion_done_irq_mask;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      window_compare_irq_mask <= RESET_VALUE[`EIM1_BIT_WINDOW];
    end else begin
      window_compare_irq_mask <= next_window_compare_irq_mask;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      two_wire_port_irq_mask <= RESET_VALUE[`EIM1_BIT_TWO_WIRE];
    end else begin
      two_wire_port_irq_mask <= next_two_wire_port_irq_mask;
    end
  end

  // Read back; bit 1 always reads zero
  assign mask_vec[`EIM1_BIT_TIMER3] = timer3_irq_mask;
  assign mask_vec[`EIM1_BIT_CMP1] = comparator1_irq_mask;
  assign mask_vec[`EIM1_BIT_CMP0] = comparator0_irq_mask;
  assign mask_vec[`EIM1_BIT_COUNTER] = counter_array_irq_mask;
  assign mask_vec[`EIM1_BIT_CONV] = conversion_done_irq_mask;
  assign mask_vec[`EIM1_BIT_WINDOW] = window_compare_irq_mask;
  assign mask_vec[`EIM1_BIT_UNUSED] = 1'h0;
  assign mask_vec[`EIM1_BIT_TWO_WIRE] = two_wire_port_irq_mask;
  assign reg_rdata = mask_vec;

  // Sources that share a vector are merged before gating
  assign raw_req[`EIM1_BIT_TIMER3] = timer3_low_overflow_flag | timer3_high_overflow_flag;
  assign raw_req[`EIM1_BIT_CMP1] = comparator1_rise_flag | comparator1_fall_flag;
  assign raw_req[`EIM1_BIT_CMP0] = comparator0_rise_flag | comparator0_fall_flag;
  assign raw_req[`EIM1_BIT_COUNTER] = |counter_array_flags;
  assign raw_req[`EIM1_BIT_CONV] = conversion_done_flag;
  assign raw_req[`EIM1_BIT_WINDOW] = window_compare_flag;
  assign raw_req[`EIM1_BIT_UNUSED] = 1'h0;
  assign raw_req[`EIM1_BIT_TWO_WIRE] = two_wire_port_flag;

  eim1_gate #(
    .WIDTH(`EIM1_NUM_SRC)
  ) u_gate (
    .raw_req(raw_req),
    .mask(mask_vec),
    .global_enable(global_irq_enable),
    .gated_req(gated_req)
  );

  always @* begin
    next_timer3_irq = gated_req[`EIM1_BIT_TIMER3];
    next_comparator1_irq = gated_req[`EIM1_BIT_CMP1];
    next_comparator0_irq = gated_req[`EIM1_BIT_CMP0];
    next_counter_array_irq = gated_req[`EIM1_BIT_COUNTER];
    next_conversion_done_irq = gated_req[`EIM1_BIT_CONV];
    next_window_compare_irq = gated_req[`EIM1_BIT_WINDOW];
    next_two_wire_port_irq = gated_req[`EIM1_BIT_TWO_WIRE];
  end

  // Registered so requests are glitch free; costs one cycle of latency
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer3_irq <= 1'h0;
    end else begin
      timer3_irq <= next_timer3_irq;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      comparator1_irq <= 1'h0;
    end else begin
      comparator1_irq <= next_comparator1_irq;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      comparator0_irq <= 1'h0;
    end else begin
      comparator0_irq <= next_comparator0_irq;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      counter_array_irq <= 1'h0;
    end else begin
      counter_array_irq <= next_counter_array_irq;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conversion_done_irq <= 1'h0;
    end else begin
      conversion_done_irq <= next_conversion_done_irq;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      window_compare_irq <= 1'h0;
    end else begin
      window_compare_irq <= next_window_compare_irq;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      two_wire_port_irq <= 1'h0;
    end else begin
      two_wire_port_irq <= next_two_wire_port_irq;
    end
  end
endmodule
